// ---- logic/dcd_pkg.sv ----
package dcd_pkg;

  // command pin order: {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic [3:0] PINS_ACT = 4'h3;
  localparam logic [3:0] PINS_RD = 4'h5;
  localparam logic [3:0] PINS_WR = 4'h4;
  localparam logic [3:0] PINS_PRE = 4'h2;
  localparam logic [3:0] PINS_REF = 4'h1;
  localparam logic [3:0] PINS_MRS = 4'h0;
  localparam logic [3:0] PINS_ZQ = 4'h6;

  typedef enum logic [8:0] {
    DCD_CMD_DESEL = 9'h001,
    DCD_CMD_NOP = 9'h002,
    DCD_CMD_ACT = 9'h004,
    DCD_CMD_RD = 9'h008,
    DCD_CMD_WR = 9'h010,
    DCD_CMD_PRE = 9'h020,
    DCD_CMD_REF = 9'h040,
    DCD_CMD_MRS = 9'h080,
    DCD_CMD_ZQ = 9'h100
  } dcd_cmd_t;

  // address bit functions
  localparam int AUTO_PRE_BIT = 10;
  localparam int BURST_CHOP_BIT = 12;

  // mode register indices and termination fields
  localparam int NUM_MR = 4;
  localparam logic [1:0] MR1_IDX = 2'h1;
  localparam logic [1:0] MR2_IDX = 2'h2;
  localparam int RTT_NOM_B0 = 2;
  localparam int RTT_NOM_B1 = 6;
  localparam int RTT_NOM_B2 = 9;
  localparam int RTT_WR_LO = 9;
  localparam int RTT_WR_HI = 10;

  // write beats per burst
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  localparam int SYNC_LEN = 3;

endpackage : dcd_pkg

// ---- logic/dcd_cmd_addr_decode.sv ----
// Behaviour
// - RAS, CAS, WE with chip select form the command code each cycle.
// - a write byte sampled with its mask high is not stored.
// - write mask sampled on both strobe edges, one mask per beat.
// - bank inputs select the bank for activate, read, write, precharge.
// - on mode register set, bank inputs choose the mode register.
// - address bit 10 on read or write requests auto precharge.
// - on precharge, bit 10 low closes one bank, high closes all.
// - single-bank precharge takes its bank from the bank inputs.
// - address inputs give row on activate, column on read and write.
// - on mode register set, address inputs are the op-code stored.
// - address bit 12 low chops the burst, high gives full burst.
// - termination control registered high enables internal termination.
// - termination applies to every data line and both strobe lines.
// - termination control ignored when mode registers disable termination.
// - chip select registered high masks every command.
// - all address and control inputs sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module dcd_cmd_addr_decode #(
  parameter int ADDR_W = 14,
  parameter int BA_W = 3,
  parameter int DQ_W = 16
) (
  input wire logic clk_i, // command clock, rising edge
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic cs_n_i, // chip select, active low
  input wire logic ras_n_i, // row strobe, active low
  input wire logic cas_n_i, // column strobe, active low
  input wire logic we_n_i, // write enable, active low
  input wire logic [BA_W-1:0] ba_i, // bank address
  input wire logic [ADDR_W-1:0] addr_i, // address inputs
  input wire logic odt_i, // termination control
  input wire logic dqs_i, // write data strobe, true side
  input wire logic [DQ_W-1:0] dq_i, // write data
  input wire logic lower_byte_write_mask_i, // mask for low byte
  input wire logic upper_byte_write_mask_i, // mask for high byte
  output logic cmd_valid_o, // one-cycle pulse per command other than nop or deselect
  output var dcd_pkg::dcd_cmd_t cmd_o, // decoded command
  output logic [BA_W-1:0] bank_o, // target bank
  output logic [ADDR_W-1:0] row_o, // row of last activate
  output logic [ADDR_W-1:0] col_o, // column of last read or write
  output logic auto_pre_o, // auto precharge on read or write
  output logic all_banks_o, // precharge of every bank
  output logic burst_chop_o, // chopped burst on read or write
  output logic mr_wr_o, // one-cycle pulse: mode register written
  output logic [1:0] mr_sel_o, // mode register selected
  output logic [ADDR_W-1:0] mr_op_o, // op-code written
  output logic term_en_o, // termination active
  output logic [DQ_W-1:0] term_dq_o, // termination per data line
  output logic [1:0] term_dqs_o, // termination on true strobes
  output logic [1:0] term_dqs_n_o, // termination on complement strobes
  output logic beat_valid_o, // one-cycle pulse per stored beat
  output logic [DQ_W-1:0] beat_data_o, // beat data
  output logic [1:0] beat_byte_en_o // bytes to store
);

  localparam int SL = dcd_pkg::SYNC_LEN;

  if (ADDR_W <= dcd_pkg::BURST_CHOP_BIT || BA_W < 2 || DQ_W != 16) begin : g_param_check
    $error("dcd_cmd_addr_decode: unsupported parameter values");
  end

  typedef struct packed {
    logic cmd_valid;
    dcd_pkg::dcd_cmd_t cmd;
    logic [BA_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic auto_pre;
    logic all_banks;
    logic burst_chop;
    logic mr_wr;
    logic [1:0] mr_sel;
    logic [ADDR_W-1:0] mr_op;
    logic [dcd_pkg::NUM_MR-1:0][ADDR_W-1:0] mr;
    logic term_en;
    logic [SL-1:0] dqs_s;
    logic [SL-1:0][1:0] dm_s;
    logic [SL-1:0][DQ_W-1:0] dq_s;
    logic dqs_lvl;
    logic [1:0] sync_fill;
    logic [3:0] beats_left;
    logic beat_valid;
    logic [DQ_W-1:0] beat_data;
    logic [1:0] beat_be;
  } dcd_state_t;

  dcd_state_t state_reg;
  dcd_state_t state_next;

  function automatic dcd_pkg::dcd_cmd_t dcd_decode(input logic [3:0] pins);
    dcd_pkg::dcd_cmd_t c;
    c = dcd_pkg::DCD_CMD_DESEL;
    if (!pins[3]) begin
      unique case (pins)
        dcd_pkg::PINS_NOP: c = dcd_pkg::DCD_CMD_NOP;
        dcd_pkg::PINS_ACT: c = dcd_pkg::DCD_CMD_ACT;
        dcd_pkg::PINS_RD: c = dcd_pkg::DCD_CMD_RD;
        dcd_pkg::PINS_WR: c = dcd_pkg::DCD_CMD_WR;
        dcd_pkg::PINS_PRE: c = dcd_pkg::DCD_CMD_PRE;
        dcd_pkg::PINS_REF: c = dcd_pkg::DCD_CMD_REF;
        dcd_pkg::PINS_MRS: c = dcd_pkg::DCD_CMD_MRS;
        default: c = dcd_pkg::DCD_CMD_ZQ;
      endcase
    end
    return c;
  endfunction : dcd_decode

  // termination stays off unless nominal or write termination is programmed
  function automatic logic dcd_rtt_on(input logic [ADDR_W-1:0] mr1, input logic [ADDR_W-1:0] mr2);
    logic on;
    on = mr1[dcd_pkg::RTT_NOM_B0] | mr1[dcd_pkg::RTT_NOM_B1] | mr1[dcd_pkg::RTT_NOM_B2]
       | (|mr2[dcd_pkg::RTT_WR_HI:dcd_pkg::RTT_WR_LO]);
    return on;
  endfunction : dcd_rtt_on

  logic [3:0] pins;
  dcd_pkg::dcd_cmd_t cmd_now;
  logic dqs_edge;
  assign pins = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign cmd_now = dcd_decode(pins);
  // a strobe edge counts once the second and third stages agree
  assign dqs_edge = (state_reg.dqs_s[1] == state_reg.dqs_s[2])
                  && (state_reg.dqs_s[2] != state_reg.dqs_lvl)
                  && (state_reg.sync_fill == 2'(SL));

  always_comb begin
    state_next = state_reg;
    state_next.cmd_valid = 1'b0;
    state_next.mr_wr = 1'b0;
    state_next.beat_valid = 1'b0;
    // command pins taken at the rising edge with no extra staging
    state_next.cmd = cmd_now;
    if (cmd_now != dcd_pkg::DCD_CMD_DESEL && cmd_now != dcd_pkg::DCD_CMD_NOP) begin
      state_next.cmd_valid = 1'b1;
    end
    unique case (cmd_now)
      dcd_pkg::DCD_CMD_ACT: begin
        state_next.bank = ba_i;
        state_next.row = addr_i;
      end
      dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR: begin
        state_next.bank = ba_i;
        state_next.col = addr_i;
        state_next.auto_pre = addr_i[dcd_pkg::AUTO_PRE_BIT];
        state_next.burst_chop = !addr_i[dcd_pkg::BURST_CHOP_BIT];
        state_next.all_banks = 1'b0;
        if (cmd_now == dcd_pkg::DCD_CMD_WR) begin
          state_next.beats_left = addr_i[dcd_pkg::BURST_CHOP_BIT]
                                ? dcd_pkg::BEATS_FULL : dcd_pkg::BEATS_CHOP;
        end
      end
      dcd_pkg::DCD_CMD_PRE: begin
        state_next.bank = ba_i;
        state_next.all_banks = addr_i[dcd_pkg::AUTO_PRE_BIT];
        state_next.auto_pre = 1'b0;
      end
      dcd_pkg::DCD_CMD_MRS: begin
        if (ba_i < BA_W'(dcd_pkg::NUM_MR)) begin
          state_next.mr_wr = 1'b1;
          state_next.mr_sel = ba_i[1:0];
          state_next.mr_op = addr_i;
          state_next.mr[ba_i[1:0]] = addr_i;
        end
      end
      default: begin
      end
    endcase
    state_next.term_en = odt_i
      && dcd_rtt_on(state_reg.mr[dcd_pkg::MR1_IDX], state_reg.mr[dcd_pkg::MR2_IDX]);
    // strobe, mask and data each pass a three stage synchroniser
    state_next.dqs_s = {state_reg.dqs_s[1:0], dqs_i};
    state_next.dm_s = {state_reg.dm_s[1:0], {upper_byte_write_mask_i, lower_byte_write_mask_i}};
    state_next.dq_s = {state_reg.dq_s[1:0], dq_i};
    // stages still hold reset zeros: follow the second stage level, no edge taken yet
    if (state_reg.sync_fill != 2'(SL)) begin
      state_next.sync_fill = state_reg.sync_fill + 2'h1;
      state_next.dqs_lvl = state_reg.dqs_s[1];
    end
    if (dqs_edge) begin
      state_next.dqs_lvl = state_reg.dqs_s[2];
      if (state_reg.beats_left != 4'h0 && cmd_now != dcd_pkg::DCD_CMD_WR) begin
        state_next.beats_left = state_reg.beats_left - 4'h1;
        state_next.beat_valid = 1'b1;
        state_next.beat_data = state_reg.dq_s[2];
        state_next.beat_be = ~state_reg.dm_s[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.cmd <= dcd_pkg::DCD_CMD_DESEL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cmd_valid_o = state_reg.cmd_valid;
  assign cmd_o = state_reg.cmd;
  assign bank_o = state_reg.bank;
  assign row_o = state_reg.row;
  assign col_o = state_reg.col;
  assign auto_pre_o = state_reg.auto_pre;
  assign all_banks_o = state_reg.all_banks;
  assign burst_chop_o = state_reg.burst_chop;
  assign mr_wr_o = state_reg.mr_wr;
  assign mr_sel_o = state_reg.mr_sel;
  assign mr_op_o = state_reg.mr_op;
  assign term_en_o = state_reg.term_en;
  assign term_dq_o = {DQ_W{state_reg.term_en}};
  assign term_dqs_o = {2{state_reg.term_en}};
  assign term_dqs_n_o = {2{state_reg.term_en}};
  assign beat_valid_o = state_reg.beat_valid;
  assign beat_data_o = state_reg.beat_data;
  assign beat_byte_en_o = state_reg.beat_be;

  a_cmd_code_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(cs_n_i) && $past(rst_n_i) |-> cmd_o == dcd_decode($past(pins)))
    else $error("command does not match sampled pins");

  a_cs_masks_cmd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_i |=> !cmd_valid_o && cmd_o == dcd_pkg::DCD_CMD_DESEL)
    else $error("command taken while chip select high");

  a_bank_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_now inside {dcd_pkg::DCD_CMD_ACT, dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR}
    |=> bank_o == $past(ba_i))
    else $error("bank not taken from bank inputs");

  a_pre_one_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_now == dcd_pkg::DCD_CMD_PRE |=> bank_o == $past(ba_i)
      && all_banks_o == $past(addr_i[dcd_pkg::AUTO_PRE_BIT]))
    else $error("precharge bank or scope wrong");

  a_auto_pre_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_now inside {dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR}
    |=> auto_pre_o == $past(addr_i[dcd_pkg::AUTO_PRE_BIT]) && !all_banks_o)
    else $error("auto precharge flag wrong");

  a_chop_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_now inside {dcd_pkg::DCD_CMD_RD, dcd_pkg::DCD_CMD_WR}
    |=> burst_chop_o != $past(addr_i[dcd_pkg::BURST_CHOP_BIT]))
    else $error("burst chop flag wrong");

  a_row_col_take: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cmd_now == dcd_pkg::DCD_CMD_ACT |=> row_o == $past(addr_i))
    and (cmd_now == dcd_pkg::DCD_CMD_RD |=> col_o == $past(addr_i)))
    else $error("row or column not captured");

  a_mrs_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_now == dcd_pkg::DCD_CMD_MRS && ba_i < BA_W'(dcd_pkg::NUM_MR)
    |=> mr_wr_o && mr_sel_o == $past(ba_i[1:0]) && mr_op_o == $past(addr_i))
    else $error("mode register write wrong");

  a_mrs_stored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mr_wr_o |-> state_reg.mr[mr_sel_o] == mr_op_o)
    else $error("op-code not stored");

  a_odt_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !dcd_rtt_on(state_reg.mr[dcd_pkg::MR1_IDX], state_reg.mr[dcd_pkg::MR2_IDX])
    |=> !term_en_o)
    else $error("termination on while disabled");

  a_odt_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    odt_i && dcd_rtt_on(state_reg.mr[dcd_pkg::MR1_IDX], state_reg.mr[dcd_pkg::MR2_IDX])
    |=> term_en_o && (&term_dq_o) && (&term_dqs_o) && (&term_dqs_n_o))
    else $error("termination not applied");

  a_mask_beat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    beat_valid_o |-> beat_byte_en_o == ~$past(state_reg.dm_s[2]))
    else $error("masked byte enabled");

  a_beat_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    beat_valid_o |-> $past(state_reg.beats_left) == state_reg.beats_left + 4'h1)
    else $error("beat count not advanced");

  a_no_warm_beat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg.sync_fill != 2'(SL) |=> !beat_valid_o)
    else $error("strobe edge taken before synchroniser filled");

  c_write_cmd: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_valid_o && cmd_o == dcd_pkg::DCD_CMD_WR);
  c_masked_beat: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    beat_valid_o && beat_byte_en_o != 2'h3);
  c_pre_all: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_o == dcd_pkg::DCD_CMD_PRE && all_banks_o);
  c_term_on: cover property (@(posedge clk_i) disable iff (!rst_n_i) term_en_o);

endmodule : dcd_cmd_addr_decode

`default_nettype wire

// ---- test/dcd_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcd_ctrl_model (
  input wire logic clk_i, // command clock
  output logic [3:0] pins_o, // {cs_n, ras_n, cas_n, we_n}
  output logic [2:0] ba_o, // bank address
  output logic [13:0] addr_o, // address
  output logic odt_o, // termination control
  output logic dqs_o, // write strobe
  output logic [15:0] dq_o, // write data
  output logic [1:0] mask_o // {upper, lower} byte masks
);
  initial begin
    pins_o = dcd_pkg::PINS_NOP;
    ba_o = 3'h0;
    addr_o = 14'h0000;
    odt_o = 1'b0;
    dqs_o = 1'b0;
    dq_o = 16'h0000;
    mask_o = 2'h0;
  end

  // one command for one cycle, then nop with the lines turned over
  task automatic issue(input logic [3:0] p, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk_i);
    #1;
    pins_o = p;
    ba_o = b;
    addr_o = a;
    @(posedge clk_i);
    #1;
    pins_o = dcd_pkg::PINS_NOP;
    ba_o = ~b;
    addr_o = ~a;
  endtask : issue

  task automatic set_odt(input logic v);
    @(posedge clk_i);
    #1;
    odt_o = v;
  endtask : set_odt

  // data settles three cycles ahead of its strobe edge
  task automatic put_beat(input logic [15:0] d, input logic [1:0] m);
    @(posedge clk_i);
    #1;
    dq_o = d;
    mask_o = m;
    repeat (3) @(posedge clk_i);
    #1;
    dqs_o = ~dqs_o;
  endtask : put_beat
endmodule : dcd_ctrl_model

`default_nettype wire

// ---- test/dcd_cmd_addr_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcd_cmd_addr_decode_test;
  localparam logic [3:0] PINS [9] = '{dcd_pkg::PINS_NOP, dcd_pkg::PINS_ACT, dcd_pkg::PINS_RD,
    dcd_pkg::PINS_WR, dcd_pkg::PINS_PRE, dcd_pkg::PINS_REF, dcd_pkg::PINS_MRS,
    dcd_pkg::PINS_ZQ, 4'h8};
  logic clk_i, rst_n_i, odt, dqs, cmd_valid, auto_pre, all_banks, chop, mr_wr, term_en, beat_v;
  logic [3:0] pins;
  logic [2:0] ba, bank;
  logic [13:0] addr, row, col, mr_op;
  logic [15:0] dq, term_dq, beat_data;
  logic [1:0] mask, mr_sel, term_dqs, term_dqs_n, byte_en;
  dcd_pkg::dcd_cmd_t cmd;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  dcd_ctrl_model ctrl (.clk_i(clk_i), .pins_o(pins), .ba_o(ba), .addr_o(addr), .odt_o(odt),
    .dqs_o(dqs), .dq_o(dq), .mask_o(mask));
  dcd_cmd_addr_decode uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(pins[3]),
    .ras_n_i(pins[2]), .cas_n_i(pins[1]), .we_n_i(pins[0]), .ba_i(ba), .addr_i(addr),
    .odt_i(odt), .dqs_i(dqs), .dq_i(dq), .lower_byte_write_mask_i(mask[0]),
    .upper_byte_write_mask_i(mask[1]), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .bank_o(bank),
    .row_o(row), .col_o(col), .auto_pre_o(auto_pre), .all_banks_o(all_banks),
    .burst_chop_o(chop), .mr_wr_o(mr_wr), .mr_sel_o(mr_sel), .mr_op_o(mr_op),
    .term_en_o(term_en), .term_dq_o(term_dq), .term_dqs_o(term_dqs), .term_dqs_n_o(term_dqs_n),
    .beat_valid_o(beat_v), .beat_data_o(beat_data), .beat_byte_en_o(byte_en));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic wait_beat(output logic got);
    got = 1'b0;
    for (int c = 0; c < 8 && !got; c++) begin
      @(posedge clk_i);
      #1;
      got = (beat_v === 1'b1);
    end
  endtask : wait_beat

  task automatic t_odt;
    ctrl.set_odt(1'b1);
    @(posedge clk_i);
    #1;
    chk("term_en idle", 0, term_en);
    ctrl.issue(dcd_pkg::PINS_MRS, 3'h1, 14'h0004);
    chk("mr_wr", 1, mr_wr);
    @(posedge clk_i);
    #1;
    chk("term_en", 1, term_en);
    chk("term_dq", 32'hFFFF, term_dq);
    chk("term_dqs", 32'hF, {term_dqs, term_dqs_n});
    ctrl.set_odt(1'b0);
    @(posedge clk_i);
    #1;
    chk("term_en low", 0, term_en);
    ctrl.issue(dcd_pkg::PINS_MRS, 3'h1, 14'h0000);
    ctrl.set_odt(1'b1);
    @(posedge clk_i);
    #1;
    chk("term_en mr off", 0, term_en);
    ctrl.issue(dcd_pkg::PINS_MRS, 3'h2, 14'h0200);
    @(posedge clk_i);
    #1;
    chk("term_en mr2", 1, term_en);
    ctrl.set_odt(1'b0);
    $display("test odt done");
  endtask : t_odt

  task automatic t_cmds;
    for (int i = 0; i < 9; i++) begin
      ctrl.issue(PINS[i], 3'h0, 14'h0000);
      chk("cmd", (i == 8) ? 32'h1 : (32'h2 << i), cmd);
      chk("cmd_valid", (i > 0 && i < 8), cmd_valid);
    end
    $display("test commands done");
  endtask : t_cmds

  task automatic t_rdwr;
    ctrl.issue(dcd_pkg::PINS_ACT, 3'h6, 14'h3FFF);
    chk("act", {3'h6, 14'h3FFF}, {bank, row});
    ctrl.issue(dcd_pkg::PINS_RD, 3'h5, 14'h0555);
    chk("rd", {3'h5, 14'h0555}, {bank, col});
    chk("rd flags", 32'h5, {auto_pre, all_banks, chop});
    ctrl.issue(dcd_pkg::PINS_WR, 3'h2, 14'h10AA);
    chk("wr", {3'h2, 14'h10AA}, {bank, col});
    chk("wr flags", 32'h0, {auto_pre, all_banks, chop});
    chk("row kept", 32'h3FFF, row);
    $display("test read write done");
  endtask : t_rdwr

  task automatic t_pre;
    ctrl.issue(dcd_pkg::PINS_PRE, 3'h3, 14'h0000);
    chk("pre one", 32'h6, {bank, all_banks});
    ctrl.issue(dcd_pkg::PINS_PRE, 3'h1, 14'h0400);
    chk("pre all", 32'h1, all_banks);
    $display("test precharge done");
  endtask : t_pre

  task automatic t_mrs;
    ctrl.issue(dcd_pkg::PINS_MRS, 3'h3, 14'h2ABC);
    chk("mrs", {1'b1, 2'h3, 14'h2ABC}, {mr_wr, mr_sel, mr_op});
    @(posedge clk_i);
    #1;
    chk("mr_wr pulse", 0, mr_wr);
    ctrl.issue(dcd_pkg::PINS_MRS, 3'h6, 14'h1111);
    chk("mrs bad", {1'b1, 1'b1, 1'b0, 14'h2ABC},
      {cmd_valid, cmd == dcd_pkg::DCD_CMD_MRS, mr_wr, mr_op});
    $display("test mode register done");
  endtask : t_mrs

  task automatic t_write;
    logic [1:0] m [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
    logic got;
    ctrl.issue(dcd_pkg::PINS_WR, 3'h0, 14'h0000);
    for (int k = 0; k < 5; k++) begin
      ctrl.put_beat(16'hA5C3 + 16'(k), m[k]);
      wait_beat(got);
      chk("beat seen", (k < 4), got);
      if (k < 4) chk("beat", {16'hA5C3 + 16'(k), ~m[k]}, {beat_data, byte_en});
    end
    $display("test write beats done");
  endtask : t_write

  // reset in mid-run with the strobe left high: no false edge may follow
  task automatic t_reset;
    logic got;
    ctrl.issue(dcd_pkg::PINS_ACT, 3'h4, 14'h0123);
    rst_n_i = 1'b0;
    #1;
    chk("reset cmd", 32'h1, cmd);
    chk("reset fields", 0, {cmd_valid, bank, row, term_en, beat_v, byte_en});
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    ctrl.issue(dcd_pkg::PINS_WR, 3'h0, 14'h0000);
    chk("cmd after reset", 32'h10, cmd);
    wait_beat(got);
    chk("no false beat", 0, got);
    ctrl.put_beat(16'h0F0F, 2'h2);
    wait_beat(got);
    chk("beat after reset", 1, got);
    chk("beat", {16'h0F0F, 2'h1}, {beat_data, byte_en});
    $display("test reset done");
  endtask : t_reset

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      results();
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_odt();
    t_cmds();
    t_rdwr();
    t_pre();
    t_mrs();
    t_write();
    t_reset();
    results();
  end
endmodule : dcd_cmd_addr_decode_test

`default_nettype wire
